// file: include/tiw_defs.svh
// constants for the t1 interrupt word block: offsets, bit positions, resets, counts
`ifndef TIW_DEFS_SVH
`define TIW_DEFS_SVH

// ****************************************
// register offsets on the processor port
// ****************************************
`define TIW_ADDR_WORD0 8'h1b
`define TIW_ADDR_WORD1 8'h1c
`define TIW_ADDR_WORD2 8'h1d

// ****************************************
// reset values and fixed masks
// ****************************************
`define TIW_WORD_RESET 8'h00
`define TIW_READ_IDLE 8'h00
`define TIW_WORD1_USED 8'hfe

// ****************************************
// word zero bit positions
// ****************************************
`define TIW_W0_TERM_SYNC 7
`define TIW_W0_MF_SYNC 6
`define TIW_W0_BOM_TRANS 5
`define TIW_W0_ALL_ONES 4
`define TIW_W0_SIG_LOSS 3
`define TIW_W0_SEVERE 2
`define TIW_W0_TX_SLIP 1
`define TIW_W0_RX_SLIP 0

// ****************************************
// word one bit positions
// ****************************************
`define TIW_W1_FRAME_ERR 7
`define TIW_W1_CRC6 6
`define TIW_W1_YELLOW 5
`define TIW_W1_ALIGN 4
`define TIW_W1_LINE_CODE 3
`define TIW_W1_TEST_PAT 2
`define TIW_W1_DENSITY 1
`define TIW_W1_UNUSED 0

// ****************************************
// counts
// ****************************************
`define TIW_ZERO_RUN_PLAIN 5'd16
`define TIW_ZERO_RUN_B8ZS 5'd8
`define TIW_SEV_WINDOW 6
`define TIW_SEV_THRESHOLD 2
`define TIW_DENS_SPAN 8
`define TIW_COUNT_WRAP_FROM 8'hff

`endif

// file: include/tiw_pkg.sv
// types shared by the t1 interrupt word block
package tiw_pkg;

    // ****************************************
    // framer status and event carrier
    // ****************************************
    typedef struct packed {
        logic terminal_sync;     // level: terminal frame sync held
        logic multiframe_sync;   // level: multiframe sync held
        logic bom_valid;         // level: a bit oriented message is being received
        logic [5:0] bom_code;    // message payload while valid
        logic all_ones;          // level: received all-ones alarm
        logic signal_loss;       // level: analog or digital loss of signal
        logic framing_bit_tick;  // pulse: one framing bit checked
        logic framing_bit_err;   // with tick: that framing bit was wrong
        logic tx_slip;           // pulse: transmit elastic buffer slipped
        logic rx_slip;           // pulse: receive elastic buffer slipped
        logic crc6_err;          // pulse: local crc-6 check failed
        logic yellow_alarm;      // pulse: yellow alarm detected
        logic alignment_change;  // pulse: reframe moved alignment
        logic line_code_viol;    // pulse: bipolar violation seen
        logic b8zs_sub;          // with violation: part of a b8zs substitution
        logic test_pattern_err;  // pulse: prbs channel error
        logic rx_bit_tick;       // pulse: one line bit received
        logic rx_bit_one;        // with tick: the bit was a mark
        logic b8zs_en;           // level: b8zs coding active
        logic [7:0] count_inc;   // pulses: one increment per error counter
    } tiw_events_s;

endpackage

// file: hdl/tiw_interrupt_words.sv
// t1 interrupt word logic: three clear-on-read event words and their event detectors
//
// Contract
// [R1] terminal sync change sets word0 bit7
// [R2] multiframe sync change sets word0 bit6
// [R3] message start or stop sets word0 bit5
// [R4] all-ones alarm change sets word0 bit4
// [R5] loss of signal change sets word0 bit3
// [R6] two framing errors in six sets bit2
// [R7] transmit slip sets word0 bit1
// [R8] receive slip sets word0 bit0
// [R9] framing bit error in sync sets word1 bit7
// [R10] crc-6 failure sets word1 bit6
// [R11] yellow alarm sets word1 bit5
// [R12] alignment change after reframe sets word1 bit4
// [R13] non-b8zs line code violation sets bit3
// [R14] prbs channel error sets word1 bit2
// [R15] sixteen zeros or low density sets bit1; the code checks density only with b8zs off
// [R16] with b8zs eight zeros sets bit1
// [R17] word1 bit0 unused, always zero
// [R18] counter wrap ff to 00 sets word2
// [R19] prbs error counter wrap sets word2 bit2
// [R20] prbs multiframe counter wrap sets bit1
// [R21] reading a word clears its bits
// [R22] masked events never set a bit
// [R23] bits stick; set beats clearing read
// [R24] error counters are eight bits, per error
`timescale 1ns/1ns
`include "tiw_defs.svh"

module tiw_interrupt_words #(
    parameter int PDV_N_MAX = 23 // largest density order checked
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire tiw_pkg::tiw_events_s events_i,
    input wire logic [7:0] unmask_word0_i,
    input wire logic [7:0] unmask_word1_i,
    input wire logic [7:0] unmask_word2_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o
);

    // ****************************************
    // sizes and elaboration checks
    // ****************************************
    localparam int HIST_LEN = `TIW_DENS_SPAN * (PDV_N_MAX + 1); // longest density window
    localparam int ONES_W = 8; // holds up to 192 ones
    localparam int FILL_W = 8;

    // the history and count widths only serve orders 1 to 23
    if (PDV_N_MAX < 1 || PDV_N_MAX > 23)
    begin : g_bad_param
        $error("PDV_N_MAX must lie between 1 and 23");
    end

    // ****************************************
    // level change detection
    // ****************************************
    logic [3:0] lvl_prev_reg; // sync, mf sync, all ones, loss
    logic [3:0] lvl_prev_next;
    logic bom_valid_prev_reg;
    logic bom_valid_prev_next;
    logic [5:0] bom_code_prev_reg;
    logic [5:0] bom_code_prev_next;
    logic primed_reg; // no change is reported before the first sample
    logic primed_next;
    logic [3:0] lvl_now;
    logic [3:0] lvl_chg;
    logic bom_chg;

    assign lvl_now = {events_i.terminal_sync, events_i.multiframe_sync,
                      events_i.all_ones, events_i.signal_loss};

    // next history and the change strobes
    always_comb
    begin
        lvl_prev_next = lvl_now;
        bom_valid_prev_next = events_i.bom_valid;
        bom_code_prev_next = events_i.bom_code;
        primed_next = 1'b1;
        lvl_chg = primed_reg ? (lvl_now ^ lvl_prev_reg) : 4'h0; // [R1] [R2] [R4] [R5]
        // new message arrives, message ends, or the code changes while held
        bom_chg = primed_reg && ((events_i.bom_valid != bom_valid_prev_reg) ||
                  (events_i.bom_valid && events_i.bom_code != bom_code_prev_reg)); // [R3]
    end

    // level history registers
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            lvl_prev_reg <= 4'h0;
            bom_valid_prev_reg <= 1'b0;
            bom_code_prev_reg <= 6'h00;
            primed_reg <= 1'b0;
        end
        else
        begin
            lvl_prev_reg <= lvl_prev_next;
            bom_valid_prev_reg <= bom_valid_prev_next;
            bom_code_prev_reg <= bom_code_prev_next;
            primed_reg <= primed_next;
        end
    end

    // ****************************************
    // severely errored frame window
    // ****************************************
    logic [`TIW_SEV_WINDOW-2:0] sev_hist_reg; // errors of the five previous framing bits
    logic [`TIW_SEV_WINDOW-2:0] sev_hist_next;
    logic sev_evt;

    // count the current bit plus the five before it
    always_comb
    begin
        sev_hist_next = sev_hist_reg;
        sev_evt = 1'b0;
        if (events_i.framing_bit_tick)
        begin
            sev_hist_next = {sev_hist_reg[`TIW_SEV_WINDOW-3:0], events_i.framing_bit_err};
            sev_evt = events_i.framing_bit_err &&
                      ($countones(sev_hist_reg) >= `TIW_SEV_THRESHOLD - 1); // [R6]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            sev_hist_reg <= '0;
        else
            sev_hist_reg <= sev_hist_next;
    end

    // ****************************************
    // pulse density monitor
    // ****************************************
    logic [4:0] zero_run_reg; // consecutive zeros, saturating at sixteen
    logic [4:0] zero_run_next;
    logic [HIST_LEN-1:0] dens_hist_reg; // newest bit in bit 0
    logic [HIST_LEN-1:0] dens_hist_next;
    logic [FILL_W-1:0] dens_fill_reg; // bits seen since reset, saturating
    logic [FILL_W-1:0] dens_fill_next;
    logic dens_prev_reg;
    logic dens_prev_next;
    logic [PDV_N_MAX-1:0] dens_viol;
    logic [4:0] zero_limit;
    logic dens_cond;
    logic pdv_evt;

    // one running ones count per order n over the last 8(n+1) bits
    for (genvar n = 1; n <= PDV_N_MAX; n++)
    begin : g_dens
        localparam int SPAN = `TIW_DENS_SPAN * (n + 1);
        logic [ONES_W-1:0] ones_reg;
        logic [ONES_W-1:0] ones_next;

        // add the arriving bit, drop the one leaving the window
        always_comb
        begin
            ones_next = ones_reg;
            if (events_i.rx_bit_tick)
                ones_next = ones_reg + ONES_W'(events_i.rx_bit_one)
                            - ONES_W'(dens_hist_reg[SPAN-1]);
        end

        always_ff @(posedge clk_i)
        begin
            if (!rst_n_i)
                ones_reg <= '0;
            else
                ones_reg <= ones_next;
        end

        // a window only judges once it has been filled
        assign dens_viol[n-1] = (dens_fill_reg >= FILL_W'(SPAN)) &&
                                (ones_reg < ONES_W'(n)); // [R15]
    end

    // zero run, history shift and density edge
    always_comb
    begin
        zero_run_next = zero_run_reg;
        dens_hist_next = dens_hist_reg;
        dens_fill_next = dens_fill_reg;
        zero_limit = events_i.b8zs_en ? `TIW_ZERO_RUN_B8ZS : `TIW_ZERO_RUN_PLAIN; // [R16]
        // density windows are only meaningful without b8zs
        dens_cond = (|dens_viol) && !events_i.b8zs_en; // [R15]
        dens_prev_next = dens_cond;
        pdv_evt = dens_cond && !dens_prev_reg;
        if (events_i.rx_bit_tick)
        begin
            dens_hist_next = {dens_hist_reg[HIST_LEN-2:0], events_i.rx_bit_one};
            if (dens_fill_reg != FILL_W'(HIST_LEN))
                dens_fill_next = dens_fill_reg + 1'b1;
            if (events_i.rx_bit_one)
                zero_run_next = 5'd0;
            else if (zero_run_reg != `TIW_ZERO_RUN_PLAIN)
                zero_run_next = zero_run_reg + 1'b1;
            // report once as the run reaches the limit, not on every later zero
            if (!events_i.rx_bit_one && (zero_run_reg + 5'd1 == zero_limit))
                pdv_evt = 1'b1; // [R15] [R16]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            zero_run_reg <= 5'd0;
            dens_hist_reg <= '0;
            dens_fill_reg <= '0;
            dens_prev_reg <= 1'b0;
        end
        else
        begin
            zero_run_reg <= zero_run_next;
            dens_hist_reg <= dens_hist_next;
            dens_fill_reg <= dens_fill_next;
            dens_prev_reg <= dens_prev_next;
        end
    end

    // ****************************************
    // performance counters and wrap detection
    // ****************************************
    logic [7:0] wrap_evt;

    for (genvar i = 0; i < 8; i++)
    begin : g_wrap
        logic [7:0] cnt_reg; // one increment per detected error
        logic [7:0] cnt_next;

        always_comb
        begin
            cnt_next = events_i.count_inc[i] ? cnt_reg + 8'h01 : cnt_reg; // [R24]
        end

        always_ff @(posedge clk_i)
        begin
            if (!rst_n_i)
                cnt_reg <= 8'h00;
            else
                cnt_reg <= cnt_next;
        end

        // the increment that rolls ff over to 00
        assign wrap_evt[i] = events_i.count_inc[i] &&
                             (cnt_reg == `TIW_COUNT_WRAP_FROM); // [R18] [R19] [R20]
    end

    // ****************************************
    // event words and read port
    // ****************************************
    logic [7:0] word0_reg;
    logic [7:0] word0_next;
    logic [7:0] word1_reg;
    logic [7:0] word1_next;
    logic [7:0] word2_reg;
    logic [7:0] word2_next;
    logic [7:0] rd_data_next;
    logic rd_valid_next;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] set2;
    logic rd0;
    logic rd1;
    logic rd2;

    // gather raw events, gate by mask, clear on read with set winning
    always_comb
    begin
        set0 = 8'h00;
        set0[`TIW_W0_TERM_SYNC] = lvl_chg[3]; // [R1]
        set0[`TIW_W0_MF_SYNC] = lvl_chg[2]; // [R2]
        set0[`TIW_W0_BOM_TRANS] = bom_chg; // [R3]
        set0[`TIW_W0_ALL_ONES] = lvl_chg[1]; // [R4]
        set0[`TIW_W0_SIG_LOSS] = lvl_chg[0]; // [R5]
        set0[`TIW_W0_SEVERE] = sev_evt; // [R6]
        set0[`TIW_W0_TX_SLIP] = events_i.tx_slip; // [R7]
        set0[`TIW_W0_RX_SLIP] = events_i.rx_slip; // [R8]
        set1 = 8'h00;
        set1[`TIW_W1_FRAME_ERR] = events_i.framing_bit_tick && events_i.framing_bit_err &&
                                  events_i.terminal_sync; // [R9]
        set1[`TIW_W1_CRC6] = events_i.crc6_err; // [R10]
        set1[`TIW_W1_YELLOW] = events_i.yellow_alarm; // [R11]
        set1[`TIW_W1_ALIGN] = events_i.alignment_change; // [R12]
        set1[`TIW_W1_LINE_CODE] = events_i.line_code_viol && !events_i.b8zs_sub; // [R13]
        set1[`TIW_W1_TEST_PAT] = events_i.test_pattern_err; // [R14]
        set1[`TIW_W1_DENSITY] = pdv_evt; // [R15] [R16]
        set0 = set0 & unmask_word0_i; // [R22]
        set1 = set1 & unmask_word1_i & `TIW_WORD1_USED; // [R17] [R22]
        set2 = wrap_evt & unmask_word2_i; // [R18] [R22]
        rd0 = reg_rd_i && (reg_addr_i == `TIW_ADDR_WORD0);
        rd1 = reg_rd_i && (reg_addr_i == `TIW_ADDR_WORD1);
        rd2 = reg_rd_i && (reg_addr_i == `TIW_ADDR_WORD2);
        // a read wipes the word, but a same-cycle event survives it
        word0_next = (rd0 ? `TIW_WORD_RESET : word0_reg) | set0; // [R21] [R23]
        word1_next = (rd1 ? `TIW_WORD_RESET : word1_reg) | set1; // [R21] [R23]
        word2_next = (rd2 ? `TIW_WORD_RESET : word2_reg) | set2; // [R21] [R23]
        // the returned value is the word before the clear; unmapped reads give zero
        rd_valid_next = reg_rd_i;
        if (rd0)
            rd_data_next = word0_reg;
        else if (rd1)
            rd_data_next = word1_reg;
        else if (rd2)
            rd_data_next = word2_reg;
        else
            rd_data_next = `TIW_READ_IDLE;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            word0_reg <= `TIW_WORD_RESET;
            word1_reg <= `TIW_WORD_RESET;
            word2_reg <= `TIW_WORD_RESET;
            rd_data_o <= `TIW_READ_IDLE;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            word0_reg <= word0_next;
            word1_reg <= word1_next;
            word2_reg <= word2_next;
            rd_data_o <= rd_data_next;
            rd_valid_o <= rd_valid_next;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_term_sync;
        primed_reg && (events_i.terminal_sync != lvl_prev_reg[3]) && unmask_word0_i[7]
        |=> reg_rd_i && reg_addr_i == `TIW_ADDR_WORD0 ##1 rd_data_o[7];
    endproperty
    a_term_sync: assert property (p_term_sync) else $error("sync change lost"); // [R1]

    property p_severe;
        events_i.framing_bit_tick && events_i.framing_bit_err && sev_hist_reg != '0 &&
        unmask_word0_i[2] |=> word0_reg[2];
    endproperty
    a_severe: assert property (p_severe) else $error("severe frame missed"); // [R6]

    property p_frame_err_out_of_sync;
        !word1_reg[7] && !events_i.terminal_sync |=> !word1_reg[7];
    endproperty
    a_frame_err_out_of_sync: assert property (p_frame_err_out_of_sync)
        else $error("framing error set out of sync"); // [R9]

    property p_line_code_sub;
        !word1_reg[3] && events_i.b8zs_sub |=> !word1_reg[3];
    endproperty
    a_line_code_sub: assert property (p_line_code_sub)
        else $error("substitution counted as violation"); // [R13]

    property p_zero_run;
        events_i.rx_bit_tick && !events_i.rx_bit_one && !events_i.b8zs_en &&
        zero_run_reg == 5'd15 && unmask_word1_i[1] |=> word1_reg[1];
    endproperty
    a_zero_run: assert property (p_zero_run) else $error("sixteen zeros missed"); // [R15]

    property p_b8zs_run;
        events_i.rx_bit_tick && !events_i.rx_bit_one && events_i.b8zs_en &&
        zero_run_reg == 5'd7 && unmask_word1_i[1] |=> word1_reg[1];
    endproperty
    a_b8zs_run: assert property (p_b8zs_run) else $error("eight zeros missed"); // [R16]

    property p_unused;
        word1_reg[0] == 1'b0 && !(rd_valid_o && rd_data_o[0] && $past(rd1));
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit set"); // [R17]

    property p_wrap;
        events_i.count_inc[7] && g_wrap[7].cnt_reg == 8'hff && unmask_word2_i[7]
        |=> word2_reg[7] && g_wrap[7].cnt_reg == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap not flagged"); // [R18] [R24]

    property p_read_clear;
        rd0 && set0 == 8'h00 |=> word0_reg == 8'h00 && rd_valid_o
        && rd_data_o == $past(word0_reg);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear"); // [R21]

    property p_masked;
        word2_reg == 8'h00 && unmask_word2_i == 8'h00 && !rd2 [*2] |-> word2_reg == 8'h00;
    endproperty
    a_masked: assert property (p_masked) else $error("masked event set a bit"); // [R22]

    property p_set_wins;
        rd1 && set1[6] |=> word1_reg[6] ##0 (!rd1 [*1] or rd1) ;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost at read"); // [R23]

    c_read_word0: cover property (rd0 && word0_reg != 8'h00);
    c_density: cover property (dens_cond && !dens_prev_reg);
    c_set_at_read: cover property (rd2 && set2 != 8'h00);

endmodule // tiw_interrupt_words

// file: tb/tiw_interrupt_words_tb.sv
// self-checking testbench for the t1 interrupt word block
`timescale 1ns/1ns
`include "tiw_defs.svh"

// ****************************************
// shared compare: counts every check, prints and counts a mismatch
// ****************************************
`define CHK(act, exp, msg) \
begin \
    total_checks++; \
    if ((act) !== (exp)) \
    begin \
        n_fail++; \
        $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, act, exp); \
    end \
end

module tiw_interrupt_words_tb;
    logic clk_i = 1'b0; // 20 mhz bench clock
    logic rst_n_i = 1'b0; // synchronous reset, held low at start
    tiw_pkg::tiw_events_s ev = '0; // framer status driven by the bench
    tiw_pkg::tiw_events_s fe; // framing bit with error
    tiw_pkg::tiw_events_s tk; // clean framing bit
    logic [7:0] um = 8'h00; // one mask value shared by all three words
    logic [7:0] addr = 8'h00; // read address
    logic rd = 1'b0; // read strobe
    logic [7:0] rd_data; // read data from the block
    logic rd_valid; // read answer marker
    logic [7:0] ev_addr [13]; // word hit by each table event
    logic [7:0] ev_exp [13]; // bit expected from each table event
    int n_fail = 0; // mismatches seen
    int total_checks = 0; // comparisons made
    logic lvl; // current table entry is a level, not a pulse

    // ****************************************
    // clock and device
    // ****************************************
    always #25 clk_i = ~clk_i;

    // small density order keeps the windows short while still checking two orders
    tiw_interrupt_words #(.PDV_N_MAX(2)) dut_u (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .events_i(ev),
        .unmask_word0_i(um),
        .unmask_word1_i(um),
        .unmask_word2_i(um),
        .reg_addr_i(addr),
        .reg_rd_i(rd),
        .rd_data_o(rd_data),
        .rd_valid_o(rd_valid)
    );

    // ****************************************
    // tasks
    // ****************************************
    // verdict and end of run, the only place the run stops
    task automatic results;
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one read: strobe for one cycle, answer looked at in the cycle it stands
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        `CHK(rd_valid, 1'b1, "read marker")
        `CHK(rd_data, e, "read data")
    endtask

    // toggle the given fields; twice in a row gives a one-cycle pulse
    task automatic flip(input tiw_pkg::tiw_events_s p);
        @(posedge clk_i);
        ev <= ev ^ p;
    endtask

    // send n line bits of one value, then let the bit tick drop
    task automatic bits(input int n, input logic v);
        repeat (n)
        begin
            @(posedge clk_i);
            ev.rx_bit_tick <= 1'b1;
            ev.rx_bit_one <= v;
        end
        @(posedge clk_i);
        ev.rx_bit_tick <= 1'b0;
    endtask

    // one event per index: pulses, levels, framing bits and counter increments
    function automatic tiw_pkg::tiw_events_s ev_one(input int k);
        tiw_pkg::tiw_events_s e;
        e = '0;
        case (k)
            0: e.tx_slip = 1'b1;
            1: e.rx_slip = 1'b1;
            2: e.crc6_err = 1'b1;
            3: e.yellow_alarm = 1'b1;
            4: e.alignment_change = 1'b1;
            5: e.line_code_viol = 1'b1;
            6: e.test_pattern_err = 1'b1;
            7: e.terminal_sync = 1'b1;
            8: e.multiframe_sync = 1'b1;
            9: e.all_ones = 1'b1;
            10: e.signal_loss = 1'b1;
            11: e.bom_valid = 1'b1;
            12:
            begin
                e.line_code_viol = 1'b1;
                e.b8zs_sub = 1'b1;
            end
            13:
            begin
                e.framing_bit_tick = 1'b1;
                e.framing_bit_err = 1'b1;
            end
            14: e.framing_bit_tick = 1'b1;
            default: e.count_inc = 8'h01 << (k - 15);
        endcase
        return e;
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        ev_addr = '{8'h1b, 8'h1b, 8'h1c, 8'h1c, 8'h1c, 8'h1c, 8'h1c,
                    8'h1b, 8'h1b, 8'h1b, 8'h1b, 8'h1b, 8'h1c};
        ev_exp = '{8'h02, 8'h01, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
                   8'h80, 8'h40, 8'h10, 8'h08, 8'h20, 8'h00};
        fe = ev_one(13);
        tk = ev_one(14);
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd_chk(8'h1b, 8'h00);
        rd_chk(8'h1c, 8'h00);
        rd_chk(8'h1d, 8'h00);
        // first pass masked, second unmasked; levels checked in both directions
        for (int m = 0; m < 2; m++)
        begin
            um <= (m == 1) ? 8'hff : 8'h00;
            for (int k = 0; k < 13; k++)
            begin
                lvl = (k >= 7 && k <= 11);
                flip(ev_one(k));
                if (!lvl)
                    flip(ev_one(k));
                rd_chk(ev_addr[k], (m == 1) ? ev_exp[k] : 8'h00);
                if (lvl)
                begin
                    flip(ev_one(k));
                    rd_chk(ev_addr[k], (m == 1) ? ev_exp[k] : 8'h00);
                end
                rd_chk(ev_addr[k], 8'h00);
            end
        end
        // event in the same cycle as the clearing read survives it
        @(posedge clk_i);
        addr <= 8'h1b;
        rd <= 1'b1;
        ev.tx_slip <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        ev.tx_slip <= 1'b0;
        #1;
        `CHK(rd_data, 8'h00, "read before set")
        rd_chk(8'h1b, 8'h02);
        // an unmapped read returns zero and clears nothing
        flip(ev_one(1));
        flip(ev_one(1));
        rd_chk(8'h1e, 8'h00);
        rd_chk(8'h1b, 8'h01);
        // framing bit errors: single, two within six, two six apart, out of sync
        flip(ev_one(7));
        rd_chk(8'h1b, 8'h80);
        flip(fe);
        flip(fe);
        rd_chk(8'h1c, 8'h80);
        rd_chk(8'h1b, 8'h00);
        repeat (3)
        begin
            flip(tk);
            flip(tk);
        end
        flip(fe);
        flip(fe);
        rd_chk(8'h1b, 8'h04);
        repeat (5)
        begin
            flip(tk);
            flip(tk);
        end
        flip(fe);
        flip(fe);
        rd_chk(8'h1b, 8'h00);
        rd_chk(8'h1c, 8'h80);
        flip(ev_one(7));
        rd_chk(8'h1b, 8'h80);
        flip(fe);
        flip(fe);
        rd_chk(8'h1c, 8'h00);
        // pulse density: fifteen zeros pass, sixteen fire, sparse ones fire
        bits(30, 1'b1);
        bits(15, 1'b0);
        bits(1, 1'b1);
        rd_chk(8'h1c, 8'h00);
        bits(16, 1'b0);
        bits(30, 1'b1);
        rd_chk(8'h1c, 8'h02);
        rd_chk(8'h1c, 8'h00);
        bits(12, 1'b0);
        bits(1, 1'b1);
        bits(12, 1'b0);
        bits(30, 1'b1);
        rd_chk(8'h1c, 8'h02);
        // with b8zs seven zeros pass and eight fire
        ev.b8zs_en <= 1'b1;
        bits(7, 1'b0);
        bits(1, 1'b1);
        rd_chk(8'h1c, 8'h00);
        bits(8, 1'b0);
        bits(1, 1'b1);
        rd_chk(8'h1c, 8'h02);
        // each counter wraps only on its 256th increment
        for (int i = 0; i < 8; i++)
        begin
            repeat (255)
            begin
                flip(ev_one(15 + i));
                flip(ev_one(15 + i));
            end
            rd_chk(8'h1d, 8'h00);
            flip(ev_one(15 + i));
            flip(ev_one(15 + i));
            rd_chk(8'h1d, 8'h01 << i);
        end
        results;
    end

    // watchdog: a hang counts as a mismatch and ends the run
    initial
    begin
        #4000000;
        n_fail++;
        results;
    end
endmodule // tiw_interrupt_words_tb
